// ### src/pck_port.sv
// Port output modes, input type, key wake and divided clock output
//
// Behaviour
// - Open drain: no pull-ups, pull-down on latch 0
// - Push-pull: strong pull-up while latch holds 1
// - P1.2 and P1.3 always open drain
// - P1.5 Schmitt input only with internal reset
// - Crystal option disables P2.0 and P2.1 entirely
// - Reset latch level from config bit, quasi mode
// - Spare port2_mode_reg1 bits: Schmitt, toggles, clock out
// - One Schmitt or TTL bit per port
// - P1.2, P1.3, P1.5 always Schmitt inputs
// - Per-pin key wake enable on port 0
// - Flag sets on enabled low pin; irq if enabled
// - Key wake request wakes from Idle and Power Down
// - Clock output only with RC or external clock
// - Clock output runs while enabled, also in Idle
// - Clock output is CPU clock divided by six
// - External clock mode: P2.0 ordinary pin unless clock out
// - Mode bits: 00 quasi, 01 push-pull, 10 input, 11 OD
// - Quasi 0-to-1 latch change boosts two clocks
//
// The implementer's own choices: register access over APB and the register addresses.
`timescale 1ns/100ps
`default_nettype none

module pck_port
    import pck_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [7:0] user_config_word1,
    input wire logic [NPINS-1:0] pin_i,
    output logic [NPINS-1:0] pin_o,
    output logic [NPINS-1:0] pin_oe,
    output logic [NPINS-1:0] pin_weak_pu,
    output logic [NPINS-1:0] schmitt_sel,
    output logic timer0_toggle_en,
    output logic timer1_toggle_en,
    output logic key_wake_irq,
    output logic wake_req
);

    // ==================================================================
    // State
    typedef struct packed {
        logic [NPINS-1:0] latch;
        logic [NPINS-1:0] mode_lo;
        logic [NPINS-1:0] mode_hi;
        logic [7:0] port2_mode_reg1_spare;
        logic [7:0] kw_enable;
        logic kw_irq_en;
        logic kw_flag;
        logic [NPINS-1:0] pin_lvl;
        logic [NPINS-1:0][1:0] boost;
        logic [1:0] div_cnt;
        logic clk_out;
        logic init_done;
        logic [31:0] rdata;
    } pck_state_s;

    pck_state_s state_reg;
    pck_state_s state_next;

    logic [2:0] osc_sel;
    logic crystal;
    logic int_reset;
    logic clk_out_on;
    logic [NPINS-1:0] pin_enabled;
    logic [NPINS-1:0][1:0] mode_eff;
    logic kw_hit;
    logic wr_stb;
    logic rd_setup;
    logic addr_ok;
    logic [NPINS-1:0] latch_wr;

    // ==================================================================
    // Configuration word decode
    assign osc_sel = user_config_word1[CFG_OSC_LSB +: 3];
    assign crystal = (osc_sel != OSC_RC) && (osc_sel != OSC_EXT_CLK);
    // Crystal options never get a clock output
    assign clk_out_on = state_reg.port2_mode_reg1_spare[PORT2_MODE_REG1_CLK_OUT_EN] && !crystal;
    assign int_reset = user_config_word1[CFG_INT_RESET];

    // ==================================================================
    // Effective mode and input enable per pin
    genvar gi;
    generate
        for (gi = 0; gi < NPINS; gi++) begin : g_pin
            always_comb begin
                if (gi == PIN_P1_2 || gi == PIN_P1_3) begin
                    mode_eff[gi] = MODE_OPEN_DRAIN;
                end else if (gi == PIN_P1_5) begin
                    mode_eff[gi] = MODE_INPUT;
                end else begin
                    mode_eff[gi] = {state_reg.mode_lo[gi], state_reg.mode_hi[gi]};
                end
                if ((gi == PIN_P2_0 || gi == PIN_P2_1) && crystal) begin
                    pin_enabled[gi] = 1'b0;
                end else if (gi == PIN_P1_5) begin
                    pin_enabled[gi] = int_reset;
                end else begin
                    pin_enabled[gi] = 1'b1;
                end
            end

            // Driver: pull-down on latch 0 except in input mode, pull-ups by mode on latch 1
            always_comb begin
                pin_o[gi] = state_reg.latch[gi];
                pin_oe[gi] = 1'b0;
                pin_weak_pu[gi] = 1'b0;
                if (!pin_enabled[gi]) begin
                    pin_o[gi] = 1'b0;
                end else if (gi == PIN_P2_0 && clk_out_on) begin
                    pin_o[gi] = state_reg.clk_out;
                    pin_oe[gi] = 1'b1;
                end else if (mode_eff[gi] == MODE_INPUT) begin
                    pin_oe[gi] = 1'b0;
                end else if (!state_reg.latch[gi]) begin
                    pin_oe[gi] = 1'b1;
                end else if (mode_eff[gi] == MODE_PUSH_PULL) begin
                    pin_oe[gi] = 1'b1;
                end else if (mode_eff[gi] == MODE_QUASI) begin
                    pin_oe[gi] = (state_reg.boost[gi] != 2'h0);
                    pin_weak_pu[gi] = 1'b1;
                end
                // Open drain with latch 1 leaves the pin released
            end

            // Input type: per-port select, fixed Schmitt on special pins
            always_comb begin
                if (gi == PIN_P1_2 || gi == PIN_P1_3 || gi == PIN_P1_5) begin
                    schmitt_sel[gi] = 1'b1;
                end else if (gi < 8) begin
                    schmitt_sel[gi] = state_reg.port2_mode_reg1_spare[PORT2_MODE_REG1_SCHMITT_P0];
                end else if (gi < 16) begin
                    schmitt_sel[gi] = state_reg.port2_mode_reg1_spare[PORT2_MODE_REG1_SCHMITT_P1];
                end else begin
                    schmitt_sel[gi] = state_reg.port2_mode_reg1_spare[PORT2_MODE_REG1_SCHMITT_P2];
                end
            end
        end
    endgenerate

    // ==================================================================
    // Key wake and interrupt outputs
    // Sampled level register keeps the flag path synchronous
    assign kw_hit = |(state_reg.kw_enable & ~state_reg.pin_lvl[7:0]);
    assign key_wake_irq = state_reg.kw_flag && state_reg.kw_irq_en;
    // Wake path bypasses the clock, which is stopped in Power Down
    assign wake_req = key_wake_irq || (state_reg.kw_irq_en && |(state_reg.kw_enable & ~pin_i[7:0]));
    assign timer0_toggle_en = state_reg.port2_mode_reg1_spare[PORT2_MODE_REG1_T0_TOGGLE];
    assign timer1_toggle_en = state_reg.port2_mode_reg1_spare[PORT2_MODE_REG1_T1_TOGGLE];

    // ==================================================================
    // APB decode: zero wait states, unmapped offsets answer with error
    assign pready = 1'b1;
    assign wr_stb = psel && penable && pwrite && addr_ok;
    assign rd_setup = psel && !penable && !pwrite;
    assign prdata = state_reg.rdata;
    assign pslverr = psel && penable && !addr_ok;

    always_comb begin
        if (paddr == OFF_P0_LATCH || paddr == OFF_P1_LATCH || paddr == OFF_P2_LATCH) begin
            addr_ok = 1'b1;
        end else if (paddr == OFF_P0_MODE_LO || paddr == OFF_P0_MODE_HI) begin
            addr_ok = 1'b1;
        end else if (paddr == OFF_P1_MODE_LO || paddr == OFF_P1_MODE_HI) begin
            addr_ok = 1'b1;
        end else if (paddr == OFF_P2_MODE_REG1 || paddr == OFF_P2_MODE_HI) begin
            addr_ok = 1'b1;
        end else if (paddr == OFF_KEY_WAKE_EN || paddr == OFF_AUX_CTRL1) begin
            addr_ok = 1'b1;
        end else if (paddr == OFF_PIN_LEVELS) begin
            addr_ok = 1'b1;
        end else begin
            addr_ok = 1'b0;
        end
    end

    // ==================================================================
    // Next state
    always_comb begin
        state_next = state_reg;
        latch_wr = state_reg.latch;
        // Register writes
        if (wr_stb) begin
            if (paddr == OFF_P0_LATCH) begin
                latch_wr[7:0] = pwdata[7:0];
            end else if (paddr == OFF_P1_LATCH) begin
                latch_wr[15:8] = pwdata[7:0];
            end else if (paddr == OFF_P2_LATCH) begin
                latch_wr[17:16] = pwdata[1:0];
            end else if (paddr == OFF_P0_MODE_LO) begin
                state_next.mode_lo[7:0] = pwdata[7:0];
            end else if (paddr == OFF_P0_MODE_HI) begin
                state_next.mode_hi[7:0] = pwdata[7:0];
            end else if (paddr == OFF_P1_MODE_LO) begin
                state_next.mode_lo[15:8] = pwdata[7:0];
            end else if (paddr == OFF_P1_MODE_HI) begin
                state_next.mode_hi[15:8] = pwdata[7:0];
            end else if (paddr == OFF_P2_MODE_REG1) begin
                state_next.mode_lo[17:16] = pwdata[1:0];
                state_next.port2_mode_reg1_spare = {pwdata[7:2], 2'b00};
            end else if (paddr == OFF_P2_MODE_HI) begin
                state_next.mode_hi[17:16] = pwdata[1:0];
            end else if (paddr == OFF_KEY_WAKE_EN) begin
                state_next.kw_enable = pwdata[7:0];
            end else if (paddr == OFF_AUX_CTRL1) begin
                state_next.kw_irq_en = pwdata[AUX_KW_IRQ_EN];
                state_next.kw_flag = pwdata[AUX_KW_FLAG];
            end
        end
        // First enabled cycle after reset loads the configured level
        if (!state_reg.init_done) begin
            latch_wr = user_config_word1[CFG_RESET_HIGH] ? RST_LATCH : ~RST_LATCH;
            state_next.init_done = 1'b1;
        end
        state_next.latch = latch_wr;
        // Hardware set beats a software clear in the same cycle
        if (kw_hit) begin
            state_next.kw_flag = 1'b1;
        end
        // Strong pull-up boost on 0-to-1 latch edges
        for (int i = 0; i < NPINS; i++) begin
            if (latch_wr[i] && !state_reg.latch[i]) begin
                state_next.boost[i] = BOOST_CYCLES;
            end else if (state_reg.boost[i] != 2'h0) begin
                state_next.boost[i] = state_reg.boost[i] - 2'h1;
            end
        end
        // Disabled inputs read as zero
        state_next.pin_lvl = pin_i & pin_enabled;
        // Divide by six: toggle every third clock
        if (!clk_out_on) begin
            state_next.div_cnt = 2'h0;
            state_next.clk_out = 1'b0;
        end else if (state_reg.div_cnt == CLK_HALF_LAST) begin
            state_next.div_cnt = 2'h0;
            state_next.clk_out = !state_reg.clk_out;
        end else begin
            state_next.div_cnt = state_reg.div_cnt + 2'h1;
        end
        // Read data captured in the setup phase
        if (rd_setup) begin
            state_next.rdata = 32'h0000_0000;
            if (paddr == OFF_P0_LATCH) begin
                state_next.rdata[7:0] = state_reg.latch[7:0];
            end else if (paddr == OFF_P1_LATCH) begin
                state_next.rdata[7:0] = state_reg.latch[15:8];
            end else if (paddr == OFF_P2_LATCH) begin
                state_next.rdata[1:0] = state_reg.latch[17:16];
            end else if (paddr == OFF_P0_MODE_LO) begin
                state_next.rdata[7:0] = state_reg.mode_lo[7:0];
            end else if (paddr == OFF_P0_MODE_HI) begin
                state_next.rdata[7:0] = state_reg.mode_hi[7:0];
            end else if (paddr == OFF_P1_MODE_LO) begin
                state_next.rdata[7:0] = state_reg.mode_lo[15:8];
            end else if (paddr == OFF_P1_MODE_HI) begin
                state_next.rdata[7:0] = state_reg.mode_hi[15:8];
            end else if (paddr == OFF_P2_MODE_REG1) begin
                state_next.rdata[7:0] = {state_reg.port2_mode_reg1_spare[7:2], state_reg.mode_lo[17:16]};
            end else if (paddr == OFF_P2_MODE_HI) begin
                state_next.rdata[1:0] = state_reg.mode_hi[17:16];
            end else if (paddr == OFF_KEY_WAKE_EN) begin
                state_next.rdata[7:0] = state_reg.kw_enable;
            end else if (paddr == OFF_AUX_CTRL1) begin
                state_next.rdata[AUX_KW_IRQ_EN] = state_reg.kw_irq_en;
                state_next.rdata[AUX_KW_FLAG] = state_reg.kw_flag;
            end else if (paddr == OFF_PIN_LEVELS) begin
                state_next.rdata[NPINS-1:0] = state_reg.pin_lvl;
            end
        end
    end

    // ==================================================================
    // State register; clock enable low freezes everything
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg.latch <= RST_LATCH;
            state_reg.mode_lo <= RST_MODE;
            state_reg.mode_hi <= RST_MODE;
            state_reg.port2_mode_reg1_spare <= RST_BYTE;
            state_reg.kw_enable <= RST_BYTE;
            state_reg.kw_irq_en <= 1'b0;
            state_reg.kw_flag <= 1'b0;
            state_reg.pin_lvl <= RST_MODE;
            state_reg.boost <= '0;
            state_reg.div_cnt <= 2'h0;
            state_reg.clk_out <= 1'b0;
            state_reg.init_done <= 1'b0;
            state_reg.rdata <= 32'h0000_0000;
        end else if (clk_en) begin
            state_reg <= state_next;
        end
    end

endmodule : pck_port

`default_nettype wire

// ### src/pck_pkg.sv
// Constants for the port configuration, key wake and clock output block
package pck_pkg;
    // ==================================================================
    // Pin map: port 0 pins 0..7, port 1 pins 8..15, port 2 pins 16..17
    localparam int NPINS = 18;
    localparam int PIN_P1_2 = 10;
    localparam int PIN_P1_3 = 11;
    localparam int PIN_P1_5 = 13;
    localparam int PIN_P2_0 = 16;
    localparam int PIN_P2_1 = 17;

    // ==================================================================
    // Register byte offsets
    localparam logic [7:0] OFF_P0_LATCH = 8'h00;
    localparam logic [7:0] OFF_P1_LATCH = 8'h04;
    localparam logic [7:0] OFF_P2_LATCH = 8'h08;
    localparam logic [7:0] OFF_P0_MODE_LO = 8'h0C;
    localparam logic [7:0] OFF_P0_MODE_HI = 8'h10;
    localparam logic [7:0] OFF_P1_MODE_LO = 8'h14;
    localparam logic [7:0] OFF_P1_MODE_HI = 8'h18;
    localparam logic [7:0] OFF_P2_MODE_REG1 = 8'h1C;
    localparam logic [7:0] OFF_P2_MODE_HI = 8'h20;
    localparam logic [7:0] OFF_KEY_WAKE_EN = 8'h24;
    localparam logic [7:0] OFF_AUX_CTRL1 = 8'h28;
    localparam logic [7:0] OFF_PIN_LEVELS = 8'h2C;

    // ==================================================================
    // Field positions
    localparam int PORT2_MODE_REG1_SCHMITT_P0 = 2;
    localparam int PORT2_MODE_REG1_SCHMITT_P1 = 3;
    localparam int PORT2_MODE_REG1_SCHMITT_P2 = 4;
    localparam int PORT2_MODE_REG1_T0_TOGGLE = 5;
    localparam int PORT2_MODE_REG1_T1_TOGGLE = 6;
    localparam int PORT2_MODE_REG1_CLK_OUT_EN = 7;
    localparam int AUX_KW_IRQ_EN = 0;
    localparam int AUX_KW_FLAG = 1;
    localparam int CFG_OSC_LSB = 0;
    localparam int CFG_INT_RESET = 3;
    localparam int CFG_RESET_HIGH = 4;

    // ==================================================================
    // Oscillator option codes; every other code is a crystal option
    localparam logic [2:0] OSC_RC = 3'h0;
    localparam logic [2:0] OSC_EXT_CLK = 3'h1;

    // Output mode codes {mode_lo, mode_hi}
    localparam logic [1:0] MODE_QUASI = 2'h0;
    localparam logic [1:0] MODE_PUSH_PULL = 2'h1;
    localparam logic [1:0] MODE_INPUT = 2'h2;
    localparam logic [1:0] MODE_OPEN_DRAIN = 2'h3;

    // ==================================================================
    // Reset values and timing
    localparam logic [NPINS-1:0] RST_LATCH = 18'h3_FFFF;
    localparam logic [NPINS-1:0] RST_MODE = 18'h0_0000;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [1:0] BOOST_CYCLES = 2'h2;
    localparam logic [1:0] CLK_HALF_LAST = 2'h2;
endpackage : pck_pkg

// ### verification/pck_port_assertions.sv
// Concurrent checks on the port block pins and bus answer
`timescale 1ns/100ps
`default_nettype none

module pck_port_assertions
    import pck_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pslverr,
    input wire logic [7:0] user_config_word1,
    input wire logic [NPINS-1:0] pin_o,
    input wire logic [NPINS-1:0] pin_oe,
    input wire logic [NPINS-1:0] pin_weak_pu,
    input wire logic [NPINS-1:0] schmitt_sel,
    input wire logic key_wake_irq,
    input wire logic wake_req
);
    // ==================================================================
    // One clock domain, so clocking and disable are shared
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Fixed pins: never pulled up, only ever driven low
    a_od_fixed_pins: assert property (
        !pin_weak_pu[PIN_P1_2] && !pin_weak_pu[PIN_P1_3] && !(pin_oe[PIN_P1_2] && pin_o[PIN_P1_2])
        && !(pin_oe[PIN_P1_3] && pin_o[PIN_P1_3])) else $error("fixed open drain pin sourced current");
    a_schmitt_fixed: assert property (
        schmitt_sel[PIN_P1_2] && schmitt_sel[PIN_P1_3] && schmitt_sel[PIN_P1_5])
        else $error("fixed pin lost its Schmitt input");
    a_p15_undriven: assert property (!pin_oe[PIN_P1_5])
        else $error("input only pin was driven");
    // One cycle of grace after the config word moves
    a_xtal_off: assert property (
        ($stable(user_config_word1) && (user_config_word1[2:0] > OSC_EXT_CLK))
        |-> (pin_oe[17:16] == 2'b00) && (pin_weak_pu[17:16] == 2'b00)) else $error("oscillator pins active");
    // Divide by six: three cycles low, three high, while running
    a_clk_high3: assert property (
        (!pin_o[PIN_P2_0] && pin_oe[PIN_P2_0] && clk_en) [*3] ##1 (pin_o[PIN_P2_0] && pin_oe[PIN_P2_0] && clk_en) [*3]
        |=> (!pin_o[PIN_P2_0] || !pin_oe[PIN_P2_0])) else $error("clock output high phase too long");
    a_clk_low3: assert property (
        (pin_o[PIN_P2_0] && pin_oe[PIN_P2_0] && clk_en) [*3] ##1 (!pin_o[PIN_P2_0] && pin_oe[PIN_P2_0] && clk_en) [*3]
        |=> (pin_o[PIN_P2_0] || !pin_oe[PIN_P2_0])) else $error("clock output low phase too long");
    // Pin 0 is kept quasi by the bench, so every high drive is a boost
    a_boost_two: assert property (
        $rose(pin_oe[0] && pin_o[0]) |=> (pin_oe[0] && pin_o[0]) ##1 !pin_oe[0])
        else $error("strong pull-up boost not two cycles");
    a_wake_follow: assert property (key_wake_irq |-> wake_req)
        else $error("pending key wake did not request wake");
    a_err_access: assert property (pslverr |-> (psel && penable))
        else $error("slave error outside access phase");
endmodule : pck_port_assertions

`default_nettype wire

// ### verification/pck_pin_model.sv
// External pin model: key switches, resistors and floating lines
`timescale 1ns/100ps
`default_nettype none

module pck_pin_model
    import pck_pkg::*;
(
    input wire logic pclk,
    input wire logic [NPINS-1:0] pin_o,
    input wire logic [NPINS-1:0] pin_oe,
    input wire logic [NPINS-1:0] pin_weak_pu,
    input wire logic [NPINS-1:0] key_low,
    output logic [NPINS-1:0] pin_i
);
    // Board resistors on the two open drain pins and on P1.5
    localparam logic [NPINS-1:0] EXT_PU = 18'h0_2C00;
    logic flip = 1'b0;

    // ==================================================================
    // Floating lines wander each cycle so a stale level is never read
    always_ff @(posedge pclk) begin
        flip <= ~flip;
    end

    // Strong drive wins, then a pressed key, then any pull-up
    always_comb begin
        for (int k = 0; k < NPINS; k++) begin
            if (pin_oe[k]) pin_i[k] = pin_o[k];
            else if (key_low[k]) pin_i[k] = 1'b0;
            else if (pin_weak_pu[k] || EXT_PU[k]) pin_i[k] = 1'b1;
            else pin_i[k] = flip ^ (k % 2 == 1);
        end
    end
endmodule : pck_pin_model

`default_nettype wire

// ### verification/pck_port_tb_top.sv
// Self-checking bench for the port, key wake and clock output block
`timescale 1ns/100ps
`default_nettype none

module pck_port_tb_top
    import pck_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic clk_en = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [7:0] cfg = 8'h18;
    logic [NPINS-1:0] key_low = 18'h0_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [NPINS-1:0] pin_i;
    logic [NPINS-1:0] pin_o;
    logic [NPINS-1:0] pin_oe;
    logic [NPINS-1:0] pin_wpu;
    logic [NPINS-1:0] schm;
    logic t0_en;
    logic t1_en;
    logic kw_irq;
    logic wake;
    logic [31:0] rd;
    logic err;
    logic [7:0] sv [5] = '{8'h04, 8'h08, 8'h10, 8'h20, 8'h40};
    int bad_count = 0;
    int check_count = 0;
    realtime t0;

    always #4 pclk = ~pclk;

    pck_port u_dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .user_config_word1(cfg), .pin_i(pin_i), .pin_o(pin_o), .pin_oe(pin_oe), .pin_weak_pu(pin_wpu),
        .schmitt_sel(schm), .timer0_toggle_en(t0_en), .timer1_toggle_en(t1_en), .key_wake_irq(kw_irq),
        .wake_req(wake));
    pck_pin_model u_pins (.pclk(pclk), .pin_o(pin_o), .pin_oe(pin_oe), .pin_weak_pu(pin_wpu),
        .key_low(key_low), .pin_i(pin_i));

    // ==================================================================
    // Helpers: compare, wait, one APB transfer
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    // Lands after the edge so registered outputs have settled
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
        #1;
    endtask : cyc

    // Starts on a fresh edge so psel is never driven twice in one step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic complete_run();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : complete_run

    // ==================================================================
    // Main sequence
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        cyc(2);
        chk("rst_pins", {pin_oe[7:0], pin_wpu[7:0]}, 16'h00FF);
        apb(1'b0, OFF_P0_LATCH, 32'h0);
        chk("rst_latch", rd, 32'h0000_00FF);
        apb(1'b0, 8'h30, 32'h0);
        chk("unmapped_rd", rd, 32'h0000_0000); // unmapped read gives zero
        chk("unmapped_err", {31'h0, err}, 32'h0000_0001); // and answers with an error
        apb(1'b0, OFF_PIN_LEVELS, 32'h0);
        chk("p15_in", rd[PIN_P1_5], 1'b1);
        // Quasi boost after a 0 to 1 latch change
        apb(1'b1, OFF_P0_LATCH, 32'h0000_00FE);
        cyc(1);
        apb(1'b1, OFF_P0_LATCH, 32'h0000_00FF);
        #1;
        chk("boost1", pin_oe[0] & pin_o[0], 1'b1);
        cyc(1);
        chk("boost2", pin_oe[0] & pin_o[0], 1'b1);
        cyc(1);
        chk("boost_end", {pin_oe[0], pin_wpu[0]}, 2'b01);
        // All four mode codes on pin 1, both latch levels
        for (int m = 0; m < 4; m++) begin
            apb(1'b1, OFF_P0_MODE_LO, {30'h0, m[1], 1'b0});
            apb(1'b1, OFF_P0_MODE_HI, {30'h0, m[0], 1'b0});
            for (int l = 0; l < 2; l++) begin
                apb(1'b1, OFF_P0_LATCH, {24'h0, 6'h3F, l[0], 1'b1});
                cyc(3);
                chk("mode_oe", pin_oe[1], (l == 0) ? (m != 2) : (m == 1));
                chk("mode_wpu", pin_wpu[1], (m == 0) && (l == 1));
                chk("mode_hi", pin_oe[1] & pin_o[1], (m == 1) && (l == 1));
            end
        end
        apb(1'b1, OFF_P0_MODE_LO, 32'h0);
        apb(1'b1, OFF_P0_MODE_HI, 32'h0);
        // Mode bits ask input only, yet P1.2 stays open drain
        apb(1'b1, OFF_P1_MODE_LO, 32'h0000_00FF);
        apb(1'b1, OFF_P1_LATCH, 32'h0000_00FB);
        cyc(1);
        chk("od_low", {pin_oe[PIN_P1_2], pin_o[PIN_P1_2], pin_wpu[PIN_P1_2]}, 3'b100);
        apb(1'b1, OFF_P1_LATCH, 32'h0000_00FF);
        cyc(2);
        chk("od_rel", {pin_oe[PIN_P1_2], pin_wpu[PIN_P1_2]}, 2'b00);
        apb(1'b0, OFF_PIN_LEVELS, 32'h0);
        chk("od_in", rd[PIN_P1_2], 1'b1);
        // Spare mode bits one at a time
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, OFF_P2_MODE_REG1, {24'h0, sv[i]});
            cyc(1);
            chk("schmitt", schm, {{2{sv[i][4]}}, {8{sv[i][3]}} | 8'h2C, {8{sv[i][2]}}});
            chk("toggles", {t1_en, t0_en}, sv[i][6:5]);
        end
        // Key wake: a pin not enabled, then an enabled one
        apb(1'b1, OFF_KEY_WAKE_EN, 32'h0000_0004);
        apb(1'b1, OFF_AUX_CTRL1, 32'h0);
        @(posedge pclk) key_low <= 18'h0_0008;
        cyc(4);
        apb(1'b0, OFF_AUX_CTRL1, 32'h0);
        chk("kw_masked", rd, 32'h0);
        @(posedge pclk) key_low <= 18'h0_0004;
        cyc(4);
        @(posedge pclk) key_low <= 18'h0_0000;
        cyc(4);
        apb(1'b0, OFF_AUX_CTRL1, 32'h0);
        chk("kw_flag", rd, 32'h0000_0002);
        chk("kw_irq_off", {31'h0, kw_irq}, 32'h0000_0000);
        apb(1'b1, OFF_AUX_CTRL1, 32'h0000_0001);
        apb(1'b0, OFF_AUX_CTRL1, 32'h0);
        chk("kw_clear", rd, 32'h1);
        // Frozen clock stands for Power Down; the request still comes
        @(posedge pclk) clk_en <= 1'b0;
        @(posedge pclk) key_low <= 18'h0_0004;
        cyc(2);
        chk("wake_pd", wake, 1'b1);
        @(posedge pclk) clk_en <= 1'b1;
        cyc(4);
        chk("kw_irq", kw_irq, 1'b1);
        @(posedge pclk) key_low <= 18'h0_0000;
        cyc(3);
        apb(1'b1, OFF_AUX_CTRL1, 32'h0);
        // Clock output under RC, then external clock
        apb(1'b1, OFF_P2_MODE_REG1, 32'h0000_0080);
        for (int c = 0; c < 2; c++) begin
            @(posedge pclk) cfg <= {5'h03, c[2:0]};
            @(posedge pin_o[PIN_P2_0]);
            t0 = $realtime;
            @(posedge pin_o[PIN_P2_0]);
            chk("clk_period", int'($realtime - t0), 32'd48);
            chk("clk_oe", pin_oe[PIN_P2_0], 1'b1);
        end
        @(posedge pclk) cfg <= 8'h1A;
        cyc(3);
        chk("xtal_off", {pin_oe[17:16], pin_wpu[17:16]}, 4'h0);
        apb(1'b0, OFF_PIN_LEVELS, 32'h0);
        chk("xtal_in", rd[17:16], 2'b00);
        apb(1'b1, OFF_P2_MODE_REG1, 32'h0);
        @(posedge pclk) cfg <= 8'h19;
        cyc(8);
        chk("ext_pin", {pin_oe[PIN_P2_0], pin_wpu[PIN_P2_0]}, 2'b01);
        // Second reset: latches low, external reset input
        @(posedge pclk) presetn <= 1'b0;
        cfg <= 8'h00;
        cyc(4);
        @(posedge pclk) presetn <= 1'b1;
        cyc(3);
        apb(1'b0, OFF_P0_LATCH, 32'h0);
        chk("rst_low", rd, 32'h0);
        apb(1'b0, OFF_PIN_LEVELS, 32'h0);
        chk("p15_off", rd[PIN_P1_5], 1'b0);
        complete_run();
    end

    // Whole run is near 250 cycles; this limit is generous
    initial begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        complete_run();
    end
endmodule : pck_port_tb_top

bind pck_port pck_port_assertions u_chk (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pslverr(pslverr), .user_config_word1(user_config_word1), .pin_o(pin_o),
    .pin_oe(pin_oe), .pin_weak_pu(pin_weak_pu), .schmitt_sel(schmitt_sel), .key_wake_irq(key_wake_irq),
    .wake_req(wake_req));

`default_nettype wire
